// File: verilog/lane_timer_defines.svh
// timing constants and reset values for the lane order and training timers
`ifndef LANE_TIMER_DEFINES_SVH
`define LANE_TIMER_DEFINES_SVH
`define CLK_PERIOD_NS        10
`define LOOPBACK_IDLE_NS     1000000
`define LOOPBACK_IDLE_SIM_NS 800
`define POLL_TS_COUNT        1024
`define POLL_TS_COUNT_SIM    48
`define CONFIG_IDLE_NS       2000000
`define CONFIG_IDLE_SIM_NS   1200
`define DETECT_QUIET_NS      12000000
`define DETECT_QUIET_SIM_NS  800
`define MEDIUM_STATE_NS      24000000
`define MEDIUM_STATE_SIM_NS  1600
`define LONG_STATE_NS        48000000
`define LONG_STATE_SIM_NS    3200
`define COMPLETION_NS        50000000
`define COMPLETION_SIM_NS    20000
`define LOOPBACK_MASTER_NS   100000000
`define LOOPBACK_MASTER_SIM_NS 4000
`define RESET_STEP_CYCLES    16
`endif

// File: verilog/lane_timer_pkg.sv
// types shared by the lane order and training timer block
package lane_timer_pkg;
  typedef enum logic [3:0] {
    RST_SERDES  = 4'h1,
    RST_PCS     = 4'h2,
    RST_CORE    = 4'h4,
    RST_DONE    = 4'h8
  } reset_state_t;
endpackage

// File: verilog/training_timer.sv
// one restartable training timer with a terminal count and expiry level
`timescale 1ns/1ns
module training_timer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             MCLK,
  input  wire logic             ARST_N,
  // control
  input  wire logic             active,
  input  wire logic             step,
  input  wire logic [WIDTH-1:0] terminal,
  // status
  output logic                  expired
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             was_active;
    logic             done;
  } timer_state_t;
  timer_state_t st_reg;
  timer_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.was_active = active;
    if (active && !st_reg.was_active) begin
      st_next.count = '0;
      st_next.done  = 1'b0;
    end else if (!active) begin
      st_next.count = '0;
      st_next.done  = 1'b0;
    end else if (step && !st_reg.done) begin
      if (st_reg.count + WIDTH'(1) >= terminal) begin
        st_next.done = 1'b1;
      end
      st_next.count = st_reg.count + WIDTH'(1);
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.done;
endmodule

// File: verilog/lane_order_timers.sv
// lane order mapping, core reset sequencing and training state timers
`timescale 1ns/1ns
`include "lane_timer_defines.svh"

// Behaviour
// - reverse input high swaps channel order; low keeps natural order
// - reversed x4: channel 3,2,1,0 feed logical lanes 0,1,2,3
// - connector lane 0 reaches logical lane 0 only when reverse matches the board wiring
// - sequence serializer then PCS resets, then release active-low core reset
// - simulation select swaps every timer terminal for its short value
// - loopback slave idle timer: 1 ms, or 800 ns simulated
// - polling active counts TS1 sent up to 1024, or 48 simulated
// - 24 ms or 1600 ns timeout for polling active, width start, recovery lock
// - 48 ms or 3200 ns timeout for polling config and recovery config
// - loopback master times out at 100 ms, or 4000 ns simulated
// - detect quiet 12ms/800ns, config idle 2ms/1200ns, completion 50ms/20us
module lane_order_timers
  import lane_timer_pkg::*;
#(
  parameter int LANES    = 4,
  parameter int DW       = 8,
  parameter bit SIMULATE = 1'b0,
  parameter int TW       = 32,
  parameter int LOOPBACK_IDLE_CYC   = (`LOOPBACK_IDLE_NS / `CLK_PERIOD_NS),
  parameter int CONFIG_IDLE_CYC     = (`CONFIG_IDLE_NS / `CLK_PERIOD_NS),
  parameter int DETECT_QUIET_CYC    = (`DETECT_QUIET_NS / `CLK_PERIOD_NS),
  parameter int MEDIUM_STATE_CYC    = (`MEDIUM_STATE_NS / `CLK_PERIOD_NS),
  parameter int LONG_STATE_CYC      = (`LONG_STATE_NS / `CLK_PERIOD_NS),
  parameter int COMPLETION_CYC      = (`COMPLETION_NS / `CLK_PERIOD_NS),
  parameter int LOOPBACK_MASTER_CYC = (`LOOPBACK_MASTER_NS / `CLK_PERIOD_NS)
) (
  // clock and reset
  input  wire logic                MCLK,
  input  wire logic                ARST_N,
  // lane order
  input  wire logic                FLIP_LANES,
  input  wire logic [LANES*DW-1:0] SERDES_RX_DATA,
  output logic      [LANES*DW-1:0] CORE_RX_DATA,
  input  wire logic [LANES*DW-1:0] CORE_TX_DATA,
  output logic      [LANES*DW-1:0] SERDES_TX_DATA,
  // reset sequencing
  input  wire logic                SERDES_READY,
  input  wire logic                PCS_READY,
  output logic                     SERDES_RESET,
  output logic                     PCS_RESET,
  output logic                     CORE_RESET_N_OUT,
  // training state indications
  input  wire logic                LOOPBACK_SLAVE_IDLE_WAIT,
  input  wire logic                POLLING_ACTIVE_STATE,
  input  wire logic                TS1_SENT,
  input  wire logic                CONFIG_IDLE_STATE,
  input  wire logic                DETECT_QUIET_STATE,
  input  wire logic                CONFIG_WIDTH_START_STATE,
  input  wire logic                RECOVERY_LOCK_STATE,
  input  wire logic                POLLING_CONFIG_STATE,
  input  wire logic                RECOVERY_CONFIG_STATE,
  input  wire logic                COMPLETION_PENDING,
  input  wire logic                LOOPBACK_MASTER_STATE,
  // timer expiry levels
  output logic                     LOOPBACK_IDLE_EXPIRED,
  output logic                     POLLING_TS_DONE,
  output logic                     CONFIG_IDLE_EXPIRED,
  output logic                     DETECT_QUIET_EXPIRED,
  output logic                     MEDIUM_STATE_EXPIRED,
  output logic                     LONG_STATE_EXPIRED,
  output logic                     COMPLETION_EXPIRED,
  output logic                     LOOPBACK_MASTER_EXPIRED
);
  localparam int NT = 8;
  localparam int RW = $clog2(`RESET_STEP_CYCLES + 1);

  // short counts round down as longest times, never below one cycle
  function automatic logic [TW-1:0] pick(input int normal_cyc, input int sim_ns);
    int s;
    s = sim_ns / `CLK_PERIOD_NS;
    if (s < 1) s = 1;
    return SIMULATE ? TW'(s) : TW'(normal_cyc);
  endfunction

  // natural or mirrored channel index for a logical lane
  function automatic int lane_src(input logic flip, input int lane);
    return flip ? (LANES - 1 - lane) : lane;
  endfunction

  typedef struct packed {
    reset_state_t       rst_state;
    logic [RW-1:0]      rst_wait;
    logic [LANES*DW-1:0] rx_data;
    logic [LANES*DW-1:0] tx_data;
  } top_state_t;
  top_state_t st_reg;
  top_state_t st_next;

  logic [LANES*DW-1:0] rx_map;
  logic [LANES*DW-1:0] tx_map;

  always_comb begin
    rx_map = '0;
    tx_map = '0;
    for (int l = 0; l < LANES; l++) begin
      rx_map[l*DW +: DW] = SERDES_RX_DATA[lane_src(FLIP_LANES, l)*DW +: DW];
      tx_map[lane_src(FLIP_LANES, l)*DW +: DW] = CORE_TX_DATA[l*DW +: DW];
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.rx_data = rx_map;
    st_next.tx_data = tx_map;
    case (st_reg.rst_state)
      RST_SERDES: begin
        if (st_reg.rst_wait != RW'(`RESET_STEP_CYCLES)) begin
          st_next.rst_wait = st_reg.rst_wait + RW'(1);
        end else if (SERDES_READY) begin
          st_next.rst_state = RST_PCS;
          st_next.rst_wait  = '0;
        end
      end
      RST_PCS: begin
        if (st_reg.rst_wait != RW'(`RESET_STEP_CYCLES)) begin
          st_next.rst_wait = st_reg.rst_wait + RW'(1);
        end else if (PCS_READY) begin
          st_next.rst_state = RST_CORE;
          st_next.rst_wait  = '0;
        end
      end
      RST_CORE: begin
        st_next.rst_state = RST_DONE;
      end
      RST_DONE: begin
        // lost lock sends everything back through the sequence
        if (!SERDES_READY || !PCS_READY) begin
          st_next.rst_state = RST_SERDES;
          st_next.rst_wait  = '0;
        end
      end
      default: begin
        st_next.rst_state = RST_SERDES;
        st_next.rst_wait  = '0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg.rst_state <= RST_SERDES;
      st_reg.rst_wait  <= '0;
      st_reg.rx_data   <= '0;
      st_reg.tx_data   <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign CORE_RX_DATA     = st_reg.rx_data;
  assign SERDES_TX_DATA   = st_reg.tx_data;
  assign SERDES_RESET     = (st_reg.rst_state == RST_SERDES);
  assign PCS_RESET        = (st_reg.rst_state == RST_SERDES) || (st_reg.rst_state == RST_PCS);
  assign CORE_RESET_N_OUT = (st_reg.rst_state == RST_DONE);

  logic [NT-1:0]        t_active;
  logic [NT-1:0]        t_step;
  logic [NT-1:0]        t_exp;
  logic [NT-1:0][TW-1:0] t_term;

  assign t_active[0] = LOOPBACK_SLAVE_IDLE_WAIT;
  assign t_term[0]   = pick(LOOPBACK_IDLE_CYC, `LOOPBACK_IDLE_SIM_NS);
  assign t_active[1] = POLLING_ACTIVE_STATE;
  assign t_term[1]   = SIMULATE ? TW'(`POLL_TS_COUNT_SIM) : TW'(`POLL_TS_COUNT);
  assign t_active[2] = CONFIG_IDLE_STATE;
  assign t_term[2]   = pick(CONFIG_IDLE_CYC, `CONFIG_IDLE_SIM_NS);
  assign t_active[3] = DETECT_QUIET_STATE;
  assign t_term[3]   = pick(DETECT_QUIET_CYC, `DETECT_QUIET_SIM_NS);
  assign t_active[4] = POLLING_ACTIVE_STATE | CONFIG_WIDTH_START_STATE | RECOVERY_LOCK_STATE;
  assign t_term[4]   = pick(MEDIUM_STATE_CYC, `MEDIUM_STATE_SIM_NS);
  assign t_active[5] = POLLING_CONFIG_STATE | RECOVERY_CONFIG_STATE;
  assign t_term[5]   = pick(LONG_STATE_CYC, `LONG_STATE_SIM_NS);
  assign t_active[6] = COMPLETION_PENDING;
  assign t_term[6]   = pick(COMPLETION_CYC, `COMPLETION_SIM_NS);
  assign t_active[7] = LOOPBACK_MASTER_STATE;
  assign t_term[7]   = pick(LOOPBACK_MASTER_CYC, `LOOPBACK_MASTER_SIM_NS);

  // time-based timers step every cycle; only the TS1 counter steps per set sent
  for (genvar i = 0; i < NT; i++) begin : g_timer
    assign t_step[i] = (i == 1) ? TS1_SENT : 1'b1;
    training_timer #(
      .WIDTH (TW)
    ) u_timer (
      .MCLK     (MCLK),
      .ARST_N   (ARST_N),
      .active   (t_active[i]),
      .step     (t_step[i]),
      .terminal (t_term[i]),
      .expired  (t_exp[i])
    );
  end

  assign LOOPBACK_IDLE_EXPIRED   = t_exp[0];
  assign POLLING_TS_DONE         = t_exp[1];
  assign CONFIG_IDLE_EXPIRED     = t_exp[2];
  assign DETECT_QUIET_EXPIRED    = t_exp[3];
  assign MEDIUM_STATE_EXPIRED    = t_exp[4];
  assign LONG_STATE_EXPIRED      = t_exp[5];
  assign COMPLETION_EXPIRED      = t_exp[6];
  assign LOOPBACK_MASTER_EXPIRED = t_exp[7];
endmodule

// File: dv/lane_order_timers_sva.sv
// checker for lane order, core reset sequencing and state timers
`timescale 1ns/1ns
module lane_order_timers_chk #(
  parameter int LANES            = 4,
  parameter int DW               = 8,
  parameter bit SIMULATE         = 1'b0,
  parameter int DETECT_QUIET_CYC = 80,
  parameter int MEDIUM_STATE_CYC = 160
) (
  // clock and reset
  input wire logic                MCLK,
  input wire logic                ARST_N,
  // lane order
  input wire logic                FLIP_LANES,
  input wire logic [LANES*DW-1:0] SERDES_RX_DATA,
  input wire logic [LANES*DW-1:0] CORE_RX_DATA,
  input wire logic [LANES*DW-1:0] CORE_TX_DATA,
  input wire logic [LANES*DW-1:0] SERDES_TX_DATA,
  // reset sequencing
  input wire logic                SERDES_READY,
  input wire logic                SERDES_RESET,
  input wire logic                PCS_RESET,
  input wire logic                CORE_RESET_N_OUT,
  // timers
  input wire logic                DETECT_QUIET_STATE,
  input wire logic                POLLING_ACTIVE_STATE,
  input wire logic                CONFIG_WIDTH_START_STATE,
  input wire logic                RECOVERY_LOCK_STATE,
  input wire logic                DETECT_QUIET_EXPIRED,
  input wire logic                MEDIUM_STATE_EXPIRED
);
  localparam int QUIET_N = SIMULATE ? 80 : DETECT_QUIET_CYC;
  localparam int MED_N   = SIMULATE ? 160 : MEDIUM_STATE_CYC;
  logic live_reg;
  int   quiet_reg;
  int   med_reg;
  function automatic logic [LANES*DW-1:0] rev(input logic [LANES*DW-1:0] d);
    for (int l = 0; l < LANES; l++) rev[l*DW+:DW] = d[(LANES-1-l)*DW+:DW];
  endfunction
  // the medium timer is shared, so one count covers all three states
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      live_reg  <= 1'b0;
      quiet_reg <= 0;
      med_reg   <= 0;
    end else begin
      live_reg  <= 1'b1;
      quiet_reg <= DETECT_QUIET_STATE ? quiet_reg + 1 : 0;
      med_reg   <= (POLLING_ACTIVE_STATE | CONFIG_WIDTH_START_STATE | RECOVERY_LOCK_STATE)
                   ? med_reg + 1 : 0;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  rx_map_a: assert property (live_reg |-> CORE_RX_DATA ==
    ($past(FLIP_LANES) ? rev($past(SERDES_RX_DATA)) : $past(SERDES_RX_DATA)))
    else $error("receive lane order wrong");
  tx_map_a: assert property (live_reg |-> SERDES_TX_DATA ==
    ($past(FLIP_LANES) ? rev($past(CORE_TX_DATA)) : $past(CORE_TX_DATA)))
    else $error("transmit lane order wrong");
  core_hold_a: assert property (CORE_RESET_N_OUT |-> !SERDES_RESET && !PCS_RESET)
    else $error("core released while serializer in reset");
  pcs_after_a: assert property ($fell(PCS_RESET) |-> !SERDES_RESET)
    else $error("pcs reset left before serializer reset");
  core_rise_a: assert property ($rose(CORE_RESET_N_OUT) |-> $past(SERDES_READY)
    && !$past(PCS_RESET)) else $error("core released too early");
  core_drop_a: assert property (CORE_RESET_N_OUT && !SERDES_READY |=>
    !CORE_RESET_N_OUT) else $error("core reset kept off after ready loss");
  quiet_time_a: assert property (DETECT_QUIET_EXPIRED == (quiet_reg > QUIET_N))
    else $error("quiet timer expiry at wrong count");
  med_time_a: assert property (MEDIUM_STATE_EXPIRED == (med_reg > MED_N))
    else $error("medium timer expiry at wrong count");
  cover property ($rose(CORE_RESET_N_OUT));
  cover property ($rose(DETECT_QUIET_EXPIRED));
  cover property (live_reg && FLIP_LANES);
endmodule
bind lane_order_timers lane_order_timers_chk #(.LANES(LANES), .DW(DW), .SIMULATE(SIMULATE),
  .DETECT_QUIET_CYC(DETECT_QUIET_CYC), .MEDIUM_STATE_CYC(MEDIUM_STATE_CYC)) chk (
  .MCLK(MCLK), .ARST_N(ARST_N), .FLIP_LANES(FLIP_LANES), .SERDES_RX_DATA(SERDES_RX_DATA),
  .CORE_RX_DATA(CORE_RX_DATA), .CORE_TX_DATA(CORE_TX_DATA), .SERDES_TX_DATA(SERDES_TX_DATA),
  .SERDES_READY(SERDES_READY), .SERDES_RESET(SERDES_RESET), .PCS_RESET(PCS_RESET),
  .CORE_RESET_N_OUT(CORE_RESET_N_OUT), .DETECT_QUIET_STATE(DETECT_QUIET_STATE),
  .POLLING_ACTIVE_STATE(POLLING_ACTIVE_STATE), .RECOVERY_LOCK_STATE(RECOVERY_LOCK_STATE),
  .CONFIG_WIDTH_START_STATE(CONFIG_WIDTH_START_STATE),
  .DETECT_QUIET_EXPIRED(DETECT_QUIET_EXPIRED), .MEDIUM_STATE_EXPIRED(MEDIUM_STATE_EXPIRED));

// File: dv/link_partner_model.sv
// link partner and serializer model feeding the receive channels
`timescale 1ns/1ns
module link_partner_model (
  // asynchronous reset
  input wire logic        ARST_N,
  // connector side
  input wire logic        board_flip,
  input wire logic [31:0] conn_lanes,
  input wire logic        stall,
  // serializer side
  output logic     [31:0] serdes_rx,
  output logic            serdes_ready,
  output logic            pcs_ready
);
  // crossed board wiring lands connector lane 0 on channel 3
  assign serdes_rx = board_flip ? {conn_lanes[7:0], conn_lanes[15:8], conn_lanes[23:16],
                                   conn_lanes[31:24]} : conn_lanes;
  // a stall models a serializer losing lock, so ready falls mid-run
  assign serdes_ready = ARST_N & ~stall;
  assign pcs_ready = serdes_ready;
endmodule

// File: dv/link_training_lane_order_timers_test.sv
// testbench for lane order, core reset sequencing and state timers
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module test_link_training_lane_order_timers;
  logic mclk = 1'b0, arst_n = 1'b0, flip = 1'b0, stall = 1'b0, ts1 = 1'b0;
  logic [31:0] conn = '0, ctx = '0, srx, crx, stx;
  logic [9:0] st = '0;
  logic [7:0] ex;
  logic sr_rdy, pc_rdy, s_rst, p_rst, c_rst_n;
  int seed = 32'h9783, err_total = 0, n_compared = 0, n;
  int ti[10] = '{0, 2, 3, 1, 4, 5, 6, 7, 8, 9};
  int to[10] = '{0, 1, 2, 3, 3, 3, 4, 4, 5, 6};
  // terminal times in ns at the simulation setting
  int tn[10] = '{800, 1200, 800, 1600, 1600, 1600, 3200, 3200, 20000, 4000};
  link_partner_model partner (.ARST_N(arst_n), .board_flip(flip), .conn_lanes(conn),
    .stall(stall), .serdes_rx(srx), .serdes_ready(sr_rdy), .pcs_ready(pc_rdy));
  lane_order_timers #(.SIMULATE(1'b1)) dut (.MCLK(mclk), .ARST_N(arst_n), .FLIP_LANES(flip),
    .SERDES_RX_DATA(srx), .CORE_RX_DATA(crx), .CORE_TX_DATA(ctx), .SERDES_TX_DATA(stx),
    .SERDES_READY(sr_rdy), .PCS_READY(pc_rdy), .SERDES_RESET(s_rst), .PCS_RESET(p_rst),
    .CORE_RESET_N_OUT(c_rst_n), .LOOPBACK_SLAVE_IDLE_WAIT(st[0]), .TS1_SENT(ts1),
    .POLLING_ACTIVE_STATE(st[1]), .CONFIG_IDLE_STATE(st[2]), .DETECT_QUIET_STATE(st[3]),
    .CONFIG_WIDTH_START_STATE(st[4]), .RECOVERY_LOCK_STATE(st[5]),
    .POLLING_CONFIG_STATE(st[6]), .RECOVERY_CONFIG_STATE(st[7]), .COMPLETION_PENDING(st[8]),
    .LOOPBACK_MASTER_STATE(st[9]), .LOOPBACK_IDLE_EXPIRED(ex[0]), .POLLING_TS_DONE(ex[7]),
    .CONFIG_IDLE_EXPIRED(ex[1]), .DETECT_QUIET_EXPIRED(ex[2]), .MEDIUM_STATE_EXPIRED(ex[3]),
    .LONG_STATE_EXPIRED(ex[4]), .COMPLETION_EXPIRED(ex[5]), .LOOPBACK_MASTER_EXPIRED(ex[6]));
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic final_report();
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bound(input int lim);
    if (n >= lim) begin
      err_total++;
      final_report();
    end
  endtask
  function automatic logic [31:0] rev(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  initial forever #5 mclk = ~mclk;
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    `CHK("reset outputs", 3'b110, {s_rst, p_rst, c_rst_n})
    arst_n = 1'b1;
    n = 0;
    while (c_rst_n !== 1'b1 && n < 100) begin tick(); n++; end
    // two 17-edge steps, one core edge, then done: 35 edges after release
    `CHK("core release edges", 35, n)
    bound(100);
    stall = 1'b1;
    tick();
    `CHK("core reset on ready loss", 1'b0, c_rst_n)
    stall = 1'b0;
    n = 0;
    while (c_rst_n !== 1'b1 && n < 100) begin tick(); n++; end
    bound(100);
    repeat (40) begin
      conn = $random(seed);
      ctx = $random(seed);
      flip = $random(seed);
      tick();
      `CHK("core lanes", conn, crx)
      `CHK("serdes lanes", flip ? rev(ctx) : ctx, stx)
    end
    // a partial run first, so each count must restart on re-entry
    for (int i = 0; i < 10; i++) begin
      st[ti[i]] = 1'b1;
      repeat (5 + {$random(seed)} % 20) tick();
      st = '0;
      tick();
      st[ti[i]] = 1'b1;
      n = 0;
      while (ex[to[i]] !== 1'b1 && n < 2100) begin tick(); n++; end
      bound(2100);
      `CHK("timer edges", tn[i] / 10 + 1, n)
      st = '0;
      tick();
      `CHK("timer clear", 1'b0, ex[to[i]])
    end
    st[1] = 1'b1;
    tick();
    repeat (47) begin
      ts1 = 1'b1;
      tick();
      ts1 = 1'b0;
      tick();
    end
    `CHK("ts count early", 1'b0, ex[7])
    ts1 = 1'b1;
    tick();
    ts1 = 1'b0;
    `CHK("ts count done", 1'b1, ex[7])
    final_report();
  end
endmodule
